//--- core/nv_cmd_pkg.sv
`default_nettype none

package nv_cmd_pkg;

    // =====================================================
    // Opcodes
    localparam logic [7:0] OP_SAVE = 8'h3C;
    localparam logic [7:0] OP_RESTORE = 8'h60;
    localparam logic [7:0] OP_AUTO_ON = 8'h59;
    localparam logic [7:0] OP_AUTO_OFF = 8'h19;
    // Write-latch set opcode is not fixed here; plain default
    localparam logic [7:0] OP_SET_LATCH_DEF = 8'h06;

    // =====================================================
    // Framing and reset values
    localparam int OPCODE_BITS = 8;
    localparam logic [3:0] BITS_FULL = 4'h8;
    localparam logic [3:0] BITS_OVER = 4'h9;
    localparam logic LATCH_RST = 1'b0;
    localparam logic AUTO_RST_ON = 1'b1;

    // =====================================================
    // Timing: sequence processing time, least time, rounded up
    localparam int CLK_PERIOD_NS = 20;
    localparam int SEQ_TIME_NS = 500;
    localparam int SEQ_CYCLES = (SEQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // =====================================================
    // Serial link states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SHIFT = 3'b010,
        ST_PAUSE = 3'b100
    } link_state_t;

endpackage

`default_nettype wire

//--- core/nv_special_command_and_pause.sv
// Function
// - Opcode 3C starts a full save, opcode 60 starts a restore.
// - Opcode 59 turns power-loss save on; volatile setting.
// - Opcode 19 turns power-loss save off; volatile setting.
// - Save runs every time, whether or not data changed.
// - Save runs only with the write latch set.
// - Write latch clears on the select rise ending a save.
// - Restore needs latch set; latch clears on the following select rise.
// - Auto-save on/off need latch set; latch clears on select rise.
// - Variants with power-loss save start with it enabled.
// - Variant without it: on/off only make the device busy.
// - Pause input low while selected freezes the sequence state.
// - Pause entered only while serial clock is low.
// - While paused, serial input ignored, serial output released.
// - Resume while serial clock low; clock toggles do not advance.
// - Latch-set opcode sets the write latch; latch resets to zero.
// - Latch clear: special opcodes ignored, standby at select rise.
// - No new save or restore accepted while one is running.
`timescale 1ns/1ps
`default_nettype none

module nv_special_command_and_pause
    import nv_cmd_pkg::*;
#(
    parameter bit HAS_AUTO_SAVE = 1'b1,
    parameter logic [7:0] OP_SET_LATCH = OP_SET_LATCH_DEF,
    parameter int BUSY_CYCLES = SEQ_CYCLES
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RSTN,
    // Serial pins
    input wire logic SCK,
    input wire logic CS_N,
    input wire logic SI,
    input wire logic HOLD_N,
    output logic SO_O,
    output logic SO_OE_N,
    // Nonvolatile control and status
    output logic SAVE_REQ,
    output logic RESTORE_REQ,
    output logic NV_BUSY,
    output logic POWER_LOSS_SAVE_EN,
    output logic WRITE_LATCH
);

    // Busy counter is 16 bits; busy must stand at least two cycles
    if (BUSY_CYCLES < 2 || BUSY_CYCLES > 65535) begin : g_busy_check
        $error("BUSY_CYCLES out of range");
    end

    // =====================================================
    // Reset release
    logic rst_s1_reg;
    logic rst_n;

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            rst_s1_reg <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_n <= rst_s1_reg;
        end
    end

    // =====================================================
    // Pin synchronisers; stage one feeds stage two only
    logic [3:0] pin_s1_reg;
    logic [3:0] pin_s2_reg;
    logic sck_prev_reg;
    logic cs_prev_reg;
    logic sck_s;
    logic cs_n_s;
    logic si_s;
    logic hold_n_s;

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_reg <= 4'hB;
            pin_s2_reg <= 4'hB;
            sck_prev_reg <= 1'b1;
            cs_prev_reg <= 1'b1;
        end else begin
            pin_s1_reg <= {HOLD_N, SI, CS_N, SCK};
            pin_s2_reg <= pin_s1_reg;
            sck_prev_reg <= pin_s2_reg[0];
            cs_prev_reg <= pin_s2_reg[1];
        end
    end

    assign sck_s = pin_s2_reg[0];
    assign cs_n_s = pin_s2_reg[1];
    assign si_s = pin_s2_reg[2];
    assign hold_n_s = pin_s2_reg[3];

    logic sck_rise;
    logic cs_fall;
    logic cs_rise;

    assign sck_rise = sck_s && !sck_prev_reg;
    assign cs_fall = !cs_n_s && cs_prev_reg;
    assign cs_rise = cs_n_s && !cs_prev_reg;

    // =====================================================
    // Link state: idle, shift, pause
    link_state_t state_reg;

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (cs_fall) begin
                        state_reg <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    if (cs_n_s) begin
                        state_reg <= ST_IDLE;
                    end else if (!hold_n_s && !sck_s) begin
                        state_reg <= ST_PAUSE;
                    end
                end
                ST_PAUSE: begin
                    if (cs_n_s) begin
                        state_reg <= ST_IDLE;
                    end else if (hold_n_s && !sck_s) begin
                        state_reg <= ST_SHIFT;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // =====================================================
    // Opcode shifter; count saturates past eight
    logic [7:0] shift_reg;
    logic [3:0] count_reg;
    logic shifting;

    assign shifting = (state_reg == ST_SHIFT) && !cs_n_s && sck_rise;

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            shift_reg <= 8'h00;
            count_reg <= 4'h0;
        end else if (cs_fall) begin
            count_reg <= 4'h0;
        end else if (shifting) begin
            shift_reg <= {shift_reg[6:0], si_s};
            if (count_reg != BITS_OVER) begin
                count_reg <= count_reg + 4'h1;
            end
        end
    end

    // =====================================================
    // Decode at select rise
    logic frame_end;
    logic frame_ok;
    logic is_special;
    logic do_special;

    assign frame_end = cs_rise && (state_reg != ST_IDLE);
    assign frame_ok = frame_end && (count_reg == BITS_FULL);
    assign is_special = (shift_reg == OP_SAVE) || (shift_reg == OP_RESTORE)
        || (shift_reg == OP_AUTO_ON) || (shift_reg == OP_AUTO_OFF);
    // A special opcode while a cycle runs is dropped and keeps the latch
    assign do_special = frame_ok && is_special && WRITE_LATCH && !NV_BUSY;

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            WRITE_LATCH <= LATCH_RST;
        end else if (do_special) begin
            WRITE_LATCH <= 1'b0;
        end else if (frame_ok && shift_reg == OP_SET_LATCH) begin
            WRITE_LATCH <= 1'b1;
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            POWER_LOSS_SAVE_EN <= AUTO_RST_ON;
        end else if (!HAS_AUTO_SAVE) begin
            POWER_LOSS_SAVE_EN <= 1'b0;
        end else if (do_special && shift_reg == OP_AUTO_ON) begin
            POWER_LOSS_SAVE_EN <= 1'b1;
        end else if (do_special && shift_reg == OP_AUTO_OFF) begin
            POWER_LOSS_SAVE_EN <= 1'b0;
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            SAVE_REQ <= 1'b0;
            RESTORE_REQ <= 1'b0;
        end else begin
            SAVE_REQ <= do_special && (shift_reg == OP_SAVE);
            RESTORE_REQ <= do_special && (shift_reg == OP_RESTORE);
        end
    end

    // =====================================================
    // Busy window for every accepted special opcode
    logic [15:0] busy_cnt_reg;

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            busy_cnt_reg <= 16'h0000;
        end else if (do_special) begin
            busy_cnt_reg <= 16'(BUSY_CYCLES);
        end else if (busy_cnt_reg != 16'h0000) begin
            busy_cnt_reg <= busy_cnt_reg - 16'h0001;
        end
    end

    assign NV_BUSY = (busy_cnt_reg != 16'h0000);

    // =====================================================
    // Serial output: driven low while selected, released when paused
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            SO_O <= 1'b0;
            SO_OE_N <= 1'b1;
        end else begin
            SO_O <= 1'b0;
            SO_OE_N <= (state_reg != ST_SHIFT) || cs_n_s;
        end
    end

    // =====================================================
    // Checks
    a_save_pulse: assert property (@(posedge CLK) disable iff (!rst_n)
        frame_ok && shift_reg == OP_SAVE && WRITE_LATCH && !NV_BUSY |=> SAVE_REQ)
        else $error("save not issued");
    a_save_needs_latch: assert property (@(posedge CLK) disable iff (!rst_n)
        SAVE_REQ |-> $past(WRITE_LATCH) && !WRITE_LATCH)
        else $error("save without latch");
    a_restore_latch: assert property (@(posedge CLK) disable iff (!rst_n)
        RESTORE_REQ |-> $past(WRITE_LATCH) && $past(cs_rise))
        else $error("restore without latch");
    a_latch_clear: assert property (@(posedge CLK) disable iff (!rst_n)
        do_special |=> !WRITE_LATCH ##0 NV_BUSY)
        else $error("latch not cleared");
    a_no_latch_ignore: assert property (@(posedge CLK) disable iff (!rst_n)
        frame_ok && is_special && !WRITE_LATCH |=> !SAVE_REQ && !RESTORE_REQ
        && $stable(POWER_LOSS_SAVE_EN))
        else $error("special acted without latch");
    a_bad_count: assert property (@(posedge CLK) disable iff (!rst_n)
        frame_end && count_reg != BITS_FULL |=> $stable(WRITE_LATCH) && !SAVE_REQ)
        else $error("partial opcode acted");
    a_auto_on: assert property (@(posedge CLK) disable iff (!rst_n)
        do_special && shift_reg == OP_AUTO_ON |=> POWER_LOSS_SAVE_EN == HAS_AUTO_SAVE)
        else $error("auto save not enabled");
    a_auto_off: assert property (@(posedge CLK) disable iff (!rst_n)
        do_special && shift_reg == OP_AUTO_OFF |=> !POWER_LOSS_SAVE_EN)
        else $error("auto save not disabled");
    a_pause_freeze: assert property (@(posedge CLK) disable iff (!rst_n)
        state_reg == ST_PAUSE && !cs_n_s |=> $stable(count_reg) && $stable(shift_reg))
        else $error("shift moved while paused");
    a_pause_release: assert property (@(posedge CLK) disable iff (!rst_n)
        state_reg == ST_PAUSE |=> SO_OE_N)
        else $error("output driven while paused");
    a_pause_entry: assert property (@(posedge CLK) disable iff (!rst_n)
        state_reg == ST_SHIFT ##1 state_reg == ST_PAUSE |-> !$past(sck_s))
        else $error("pause entered with clock high");
    a_busy_len: assert property (@(posedge CLK) disable iff (!rst_n)
        do_special |=> NV_BUSY [*2])
        else $error("busy too short");

    c_save: cover property (@(posedge CLK) disable iff (!rst_n) SAVE_REQ);
    c_restore: cover property (@(posedge CLK) disable iff (!rst_n) RESTORE_REQ);
    c_auto_off: cover property (@(posedge CLK) disable iff (!rst_n)
        $fell(POWER_LOSS_SAVE_EN));
    c_pause: cover property (@(posedge CLK) disable iff (!rst_n)
        state_reg == ST_PAUSE ##1 state_reg == ST_SHIFT);

endmodule

`default_nettype wire

//--- tb/spi_master_model.sv
`timescale 1ns/1ps
`default_nettype none

module spi_master_model (
    // Clock
    input wire logic CLK,
    // Serial pins
    output logic SCK,
    output logic CS_N,
    output logic SI,
    output logic HOLD_N
);
    logic pause_probe;
    logic drive_probe;

    initial begin
        SCK = 1'b1;
        CS_N = 1'b1;
        SI = 1'b0;
        HOLD_N = 1'b1;
        pause_probe = 1'b0;
        drive_probe = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask

    // =====================================================
    // Mode 3 frame: data set on the fall, taken on the rise
    task automatic send(input logic [8:0] v, input int n, input int pause_at);
        CS_N = 1'b0;
        wait_clk(4);
        drive_probe = 1'b1;
        for (int i = n - 1; i >= 0; i--) begin
            SCK = 1'b0;
            SI = v[i];
            wait_clk(4);
            if (i == pause_at) begin
                drive_probe = 1'b0;
                HOLD_N = 1'b0;
                wait_clk(6);
                pause_probe = 1'b1;
                // Extra edges and noise must not count as bits
                repeat (2) begin
                    SCK = 1'b1;
                    SI = ~SI;
                    wait_clk(4);
                    SCK = 1'b0;
                    wait_clk(4);
                end
                pause_probe = 1'b0;
                SI = v[i];
                HOLD_N = 1'b1;
                wait_clk(4);
                drive_probe = 1'b1;
            end
            SCK = 1'b1;
            wait_clk(4);
        end
        drive_probe = 1'b0;
        CS_N = 1'b1;
        // Released line must not keep the last bit
        SI = ~SI;
        wait_clk(4);
    endtask
endmodule

`default_nettype wire

//--- tb/test_nv_special_command_and_pause.sv
`timescale 1ns/1ps
`default_nettype none

`define CHECK(nm, expv, gotv) \
    begin \
        n_tests++; \
        if ((gotv) !== (expv)) begin \
            n_errors++; \
            $display("unexpected %s: expected %h seen %h", nm, expv, gotv); \
        end \
    end

module test_nv_special_command_and_pause;
    import nv_cmd_pkg::*;

    logic clk = 1'b0;
    logic rstn = 1'b0;
    wire sck;
    wire cs_n;
    wire si;
    wire hold_n;
    logic so_o, so_oe_n, save_req, restore_req, nv_busy, pls_en, write_latch, busy_q;
    logic so_o_b, so_oe_n_b, save_req_b, restore_req_b, nv_busy_b, pls_en_b;
    logic write_latch_b, busy_b_q;
    int busy_b_cnt = 0;
    int busy_len = 0;
    localparam int BUSY = 2;
    int n_errors = 0;
    int n_tests = 0;
    int cycles = 0;
    int save_cnt = 0;
    int restore_cnt = 0;
    int busy_cnt = 0;

    always #10 clk = ~clk;

    nv_special_command_and_pause #(.BUSY_CYCLES(BUSY)) nv_special_command_and_pause_inst (
        .CLK(clk), .RSTN(rstn), .SCK(sck), .CS_N(cs_n), .SI(si), .HOLD_N(hold_n),
        .SO_O(so_o), .SO_OE_N(so_oe_n), .SAVE_REQ(save_req), .RESTORE_REQ(restore_req),
        .NV_BUSY(nv_busy), .POWER_LOSS_SAVE_EN(pls_en), .WRITE_LATCH(write_latch));

    // Variant without power-loss save, fed the same frames
    nv_special_command_and_pause #(.HAS_AUTO_SAVE(1'b0), .BUSY_CYCLES(BUSY))
        nv_special_command_and_pause_inst_noauto (
        .CLK(clk), .RSTN(rstn), .SCK(sck), .CS_N(cs_n), .SI(si), .HOLD_N(hold_n),
        .SO_O(so_o_b), .SO_OE_N(so_oe_n_b), .SAVE_REQ(save_req_b),
        .RESTORE_REQ(restore_req_b), .NV_BUSY(nv_busy_b), .POWER_LOSS_SAVE_EN(pls_en_b),
        .WRITE_LATCH(write_latch_b));

    spi_master_model spi_master_model_inst (
        .CLK(clk), .SCK(sck), .CS_N(cs_n), .SI(si), .HOLD_N(hold_n));

    // =====================================================
    // Monitors on the falling edge, where outputs are settled
    always @(negedge clk) begin
        cycles++;
        busy_q <= nv_busy;
        if (save_req === 1'b1) save_cnt++;
        if (restore_req === 1'b1) restore_cnt++;
        if (nv_busy === 1'b1 && busy_q !== 1'b1) busy_cnt++;
        if (nv_busy === 1'b1) busy_len++;
        busy_b_q <= nv_busy_b;
        if (nv_busy_b === 1'b1 && busy_b_q !== 1'b1) busy_b_cnt++;
        if (spi_master_model_inst.pause_probe) `CHECK("SO_OE_N paused", 1'b1, so_oe_n)
        if (spi_master_model_inst.drive_probe) `CHECK("SO_OE_N selected", 1'b0, so_oe_n)
        // Whole run needs about 1500 cycles
        if (cycles == 8000) begin
            n_errors++;
            test_done();
        end
    end

    task automatic test_done;
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic frame(input logic [8:0] v, input int n, input int p);
        spi_master_model_inst.send(v, n, p);
        spi_master_model_inst.wait_clk(6);
    endtask

    task automatic op(input logic [7:0] code);
        frame({1'b0, code}, 8, -1);
    endtask

    // =====================================================
    // Scenarios
    task automatic t_reset;
        `CHECK("latch at reset", LATCH_RST, write_latch)
        `CHECK("auto save at reset", AUTO_RST_ON, pls_en)
        `CHECK("SO_OE_N idle", 1'b1, so_oe_n)
        `CHECK("SO_O idle", 1'b0, so_o)
        `CHECK("auto save without feature", 1'b0, pls_en_b)
    endtask

    task automatic t_no_latch;
        op(OP_SAVE);
        op(OP_AUTO_OFF);
        `CHECK("save without latch", 0, save_cnt)
        `CHECK("busy without latch", 0, busy_cnt)
        `CHECK("auto off without latch", 1'b1, pls_en)
    endtask

    task automatic t_save;
        for (int i = 1; i <= 2; i++) begin
            op(OP_SET_LATCH_DEF);
            `CHECK("latch set", 1'b1, write_latch)
            op(OP_SAVE);
            `CHECK("save pulses", i, save_cnt)
            `CHECK("latch after save", 1'b0, write_latch)
            `CHECK("busy count", i, busy_cnt)
        end
    endtask

    task automatic t_restore;
        op(OP_SET_LATCH_DEF);
        op(OP_RESTORE);
        `CHECK("restore pulses", 1, restore_cnt)
        `CHECK("no save on restore", 2, save_cnt)
        `CHECK("latch after restore", 1'b0, write_latch)
    endtask

    task automatic t_auto;
        op(OP_SET_LATCH_DEF);
        op(OP_AUTO_OFF);
        `CHECK("auto off", 1'b0, pls_en)
        `CHECK("latch after auto off", 1'b0, write_latch)
        op(OP_SET_LATCH_DEF);
        op(OP_AUTO_ON);
        `CHECK("auto on", 1'b1, pls_en)
        `CHECK("latch after auto on", 1'b0, write_latch)
        `CHECK("busy starts", 5, busy_cnt)
        `CHECK("busy cycles", 5 * BUSY, busy_len)
        `CHECK("no-auto variant busy starts", 5, busy_b_cnt)
        `CHECK("no-auto variant enable", 1'b0, pls_en_b)
    endtask

    task automatic t_count;
        op(OP_SET_LATCH_DEF);
        // Both frames leave the save opcode in the shifter; only the count differs
        frame({1'b0, OP_SAVE}, 9, -1);
        frame({2'b00, OP_SAVE[6:0]}, 7, -1);
        `CHECK("odd frames no save", 2, save_cnt)
        `CHECK("odd frames keep latch", 1'b1, write_latch)
        op(OP_SAVE);
        `CHECK("save after odd frames", 3, save_cnt)
    endtask

    task automatic t_pause;
        op(OP_SET_LATCH_DEF);
        frame({1'b0, OP_RESTORE}, 8, 3);
        `CHECK("restore across pause", 2, restore_cnt)
        `CHECK("latch after paused frame", 1'b0, write_latch)
    endtask

    initial begin
        repeat (16) @(posedge clk);
        #1;
        rstn = 1'b1;
        spi_master_model_inst.wait_clk(8);
        t_reset();
        t_no_latch();
        t_save();
        t_restore();
        t_auto();
        t_count();
        t_pause();
        test_done();
    end
endmodule

`default_nettype wire
